//--- hdl/measure_and_memory_cmds.sv
`timescale 1ns/1ns
// Contract
// - Combined query: voltage, current, status byte
// - Status bits: output, list, error pending
// - Status bit 3 is regulation mode
// - Bit 5 fault, bit 4 protect
// - Current query returns measured current
// - Voltage query returns sense voltage
// - Sync mode: update within 60 ms
// - Power-up free running, 25 ms
// - Mode query returns sync keyword
// - Rate accepts 50, 60, 100 only
// - Power-up rate 60 or 100
// - Transient query: up to eight samples
// - Segment readback: type, value, amplitude, offset
// - Angles only for non-default sine, triangle
// - Bad segment: no reply, queue error
// - Location write stores, output unchanged
// - Mode: voltage, current, pin selected
// - Protect fields map per mode
// - Reference mode: four sources
// - Protect mode: digital, analog, smaller
// - Zero setpoints first, omitted fields zero except output, which keeps its live state
// - Locations 01 through 99 valid
module measure_and_memory_cmds
  import combined_measure_query_mem_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [15:0] cmd_arg,
  input wire logic [6:0] loc_num,
  input wire logic [7:0] loc_present,
  input wire logic [1:0] loc_mode,
  input wire logic [15:0] loc_vset,
  input wire logic [15:0] loc_cset,
  input wire logic [15:0] loc_pprot,
  input wire logic [15:0] loc_nprot,
  input wire logic loc_out,
  input wire logic [1:0] loc_ref,
  input wire logic [1:0] loc_pmode,
  input wire logic meter_fast,
  input wire logic [15:0] voltage_measure_query,
  input wire logic [15:0] current_measure_query,
  input wire logic output_on,
  input wire logic list_running,
  input wire logic errors_queued,
  input wire logic current_regulation,
  input wire logic protect_active,
  input wire logic fault_no_power,
  input wire logic setpoint_changed,
  input wire logic [3:0] tran_count,
  input wire logic [15:0] tran_sample,
  output logic [2:0] tran_index,
  input wire logic [4:0] seg_loaded,
  input wire logic [2:0] seg_type,
  input wire logic [15:0] seg_val1,
  input wire logic [15:0] seg_val2,
  input wire logic [15:0] seg_val3,
  input wire logic [15:0] seg_start,
  input wire logic [15:0] seg_stop,
  input wire logic [6:0] recall_loc,
  output logic [70:0] recall_data,
  output logic reply_valid,
  output logic [2:0] reply_kind,
  output logic [15:0] reply_word,
  output logic reply_last,
  output logic busy,
  output logic error_push,
  output logic [7:0] measurement_status_byte,
  output logic sync_mode,
  output logic [6:0] sample_rate
);
  // =====================================================
  // Reply sequencer
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_SEND = 2'b01
  } state_t;
  state_t state_q;
  logic [3:0] op_q;
  logic [2:0] idx_q;
  logic [2:0] last_idx_q;
  logic [15:0] volt_q;
  logic [15:0] curr_q;
  logic rate_init_q;
  logic [70:0] loc_mem [LOC_DEPTH];
  logic sample_stb;

  update_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .sync_mode(sync_mode),
    .setpoint_changed(setpoint_changed),
    .sample_stb(sample_stb)
  );

  // =====================================================
  // Status byte assembly
  wire [7:0] status_d = {2'b00, fault_no_power, protect_active, current_regulation,
                         errors_queued, list_running, output_on};

  // =====================================================
  // Command decode
  wire is_cmd = cmd_valid && (state_q == S_IDLE);
  wire rate_ok = (cmd_arg[6:0] == RATE_50) || (cmd_arg[6:0] == RATE_60)
                 || (cmd_arg[6:0] == RATE_100);
  wire rate_arg_ok = rate_ok && (cmd_arg[15:7] == 9'h0);
  wire loc_ok = (loc_num >= LOC_MIN) && (loc_num <= LOC_MAX);
  wire seg_ok = ({11'h0, seg_loaded} > cmd_arg);
  wire angles_default = ((seg_start == 16'h0) || (seg_start == ANGLE_360))
                        && ((seg_stop == 16'h0) || (seg_stop == ANGLE_360));
  wire seg_angles = ((seg_type == SEG_SINE) || (seg_type == SEG_TRIANGLE))
                    && !angles_default;
  wire [2:0] seg_last = seg_angles ? 3'h5 : ((seg_type == SEG_LEVEL) ? 3'h2 : 3'h3);
  wire [2:0] tran_last = (tran_count == 4'h0) ? 3'h0 : 3'(tran_count - 4'h1);
  wire tran_empty = (tran_count == 4'h0);
  wire start_reply = is_cmd && (
    (cmd_code == CMD_COMBINED) || (cmd_code == CMD_CURR) || (cmd_code == CMD_VOLT) ||
    (cmd_code == CMD_SYNC_QRY) || (cmd_code == CMD_RATE_QRY) ||
    ((cmd_code == CMD_TRAN_QRY) && !tran_empty) ||
    ((cmd_code == CMD_SEG_QRY) && seg_ok));
  wire [2:0] last_d = (cmd_code == CMD_COMBINED) ? 3'h2 :
                      (cmd_code == CMD_TRAN_QRY) ? tran_last :
                      (cmd_code == CMD_SEG_QRY) ? seg_last : 3'h0;
  wire bad_cmd = is_cmd && (((cmd_code == CMD_RATE_SET) && !rate_arg_ok) ||
                            ((cmd_code == CMD_SEG_QRY) && !seg_ok) ||
                            ((cmd_code == CMD_LOC_WRITE) && !loc_ok));

  // =====================================================
  // Location write image: zero first (output state from output_on), then supplied fields
  wire [1:0] img_mode = loc_present[F_MODE] ? loc_mode : 2'(REG_VOLT);
  wire [15:0] img_vset = loc_present[F_VSET] ? loc_vset : 16'h0;
  wire [15:0] img_cset = loc_present[F_CSET] ? loc_cset : 16'h0;
  wire [15:0] img_pprot = loc_present[F_PPROT] ? loc_pprot : 16'h0;
  wire [15:0] img_nprot = loc_present[F_NPROT] ? loc_nprot : 16'h0;
  wire img_out = loc_present[F_OUT] ? loc_out : output_on;
  wire [1:0] img_ref = loc_present[F_REF] ? loc_ref : 2'(REF_FIXED);
  wire [1:0] img_pmode = loc_present[F_PMODE] ? loc_pmode : 2'(PROT_DIGITAL);
  // Layout: pmode, ref, out, nprot, pprot, cset, vset, mode (LSB)
  wire [70:0] loc_image = {img_pmode, img_ref, img_out, img_nprot, img_pprot, img_cset, img_vset, img_mode};
  wire loc_we = is_cmd && (cmd_code == CMD_LOC_WRITE) && loc_ok;

  // =====================================================
  // Reply word select
  wire [15:0] seg_word = (idx_q == 3'h0) ? {13'h0, seg_type} :
                         (idx_q == 3'h1) ? seg_val1 :
                         (idx_q == 3'h2) ? seg_val2 :
                         (idx_q == 3'h3) ? seg_val3 :
                         (idx_q == 3'h4) ? seg_start : seg_stop;
  wire [15:0] comb_word = (idx_q == 3'h0) ? volt_q :
                          (idx_q == 3'h1) ? curr_q : {8'h0, measurement_status_byte};
  wire [3:0] op_w = op_q;
  wire [15:0] word_d = (op_w == CMD_COMBINED) ? comb_word :
                       (op_w == CMD_CURR) ? curr_q :
                       (op_w == CMD_VOLT) ? volt_q :
                       (op_w == CMD_SYNC_QRY) ? {15'h0, sync_mode} :
                       (op_w == CMD_RATE_QRY) ? {9'h0, sample_rate} :
                       (op_w == CMD_TRAN_QRY) ? tran_sample : seg_word;
  wire [2:0] kind_d = ((op_w == CMD_COMBINED) && (idx_q == 3'h2)) ? RK_STATUS :
                      (op_w == CMD_SYNC_QRY) ? RK_KEYWORD :
                      (op_w == CMD_RATE_QRY) ? RK_INT :
                      ((op_w == CMD_SEG_QRY) && (idx_q == 3'h0)) ? RK_SEGTYPE : RK_NUM;

  // =====================================================
  // Sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      op_q <= 4'h0;
      idx_q <= 3'h0;
      last_idx_q <= 3'h0;
      reply_valid <= 1'b0;
      reply_kind <= 3'h0;
      reply_word <= 16'h0;
      reply_last <= 1'b0;
      busy <= 1'b0;
      error_push <= 1'b0;
    end else begin
      error_push <= bad_cmd;
      reply_valid <= 1'b0;
      reply_last <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (start_reply) begin
            state_q <= S_SEND;
            op_q <= cmd_code;
            idx_q <= 3'h0;
            last_idx_q <= last_d;
            busy <= 1'b1;
          end
        end
        S_SEND: begin
          reply_valid <= 1'b1;
          reply_word <= word_d;
          reply_kind <= kind_d;
          reply_last <= (idx_q == last_idx_q);
          if (idx_q == last_idx_q) begin
            state_q <= S_IDLE;
            busy <= 1'b0;
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tran_index <= 3'h0;
    end else begin
      tran_index <= (state_q == S_SEND) ? (idx_q + 3'h1) : 3'h0;
    end
  end

  // =====================================================
  // Measurement capture and settings
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      volt_q <= 16'h0;
      curr_q <= 16'h0;
      measurement_status_byte <= 8'h00;
    end else begin
      measurement_status_byte <= status_d;
      if (sample_stb) begin
        volt_q <= voltage_measure_query;
        curr_q <= current_measure_query;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_mode <= 1'b0;
      sample_rate <= RATE_60;
      rate_init_q <= 1'b0;
    end else begin
      if (!rate_init_q) begin
        // Strap taken one clock after release, never under reset
        rate_init_q <= 1'b1;
        sample_rate <= meter_fast ? RATE_100 : RATE_60;
      end else if (is_cmd && (cmd_code == CMD_RATE_SET) && rate_arg_ok) begin
        sample_rate <= cmd_arg[6:0];
      end
      if (is_cmd && (cmd_code == CMD_SYNC_SET)) sync_mode <= cmd_arg[0];
    end
  end

  // =====================================================
  // Stored setups; writing never touches the live output
  always_ff @(posedge clk) begin
    if (loc_we) loc_mem[loc_num] <= loc_image;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      recall_data <= 71'h0;
    end else begin
      recall_data <= loc_mem[recall_loc];
    end
  end

  // =====================================================
  // Checks
  a_status_bits: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> measurement_status_byte == {2'b00, $past(fault_no_power), $past(protect_active),
      $past(current_regulation), $past(errors_queued), $past(list_running), $past(output_on)})
    else $error("status byte mismatch");

  a_status_top_zero: assert property (@(posedge clk) disable iff (!rst_b)
    measurement_status_byte[7:6] == 2'b00) else $error("unused status bits set");

  a_combined_three: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_COMBINED) |=> ##1 reply_valid ##1 reply_valid ##1 (reply_valid && reply_last
      && reply_kind == RK_STATUS)) else $error("combined reply not three words");

  a_bad_rate: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_RATE_SET && !rate_arg_ok) |=> $stable(sample_rate) && error_push)
    else $error("illegal rate accepted");

  a_rate_legal: assert property (@(posedge clk) disable iff (!rst_b)
    rate_init_q |-> (sample_rate == RATE_50 || sample_rate == RATE_60 || sample_rate == RATE_100))
    else $error("rate out of set");

  a_seg_silent: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_SEG_QRY && !seg_ok) |=> error_push && !busy ##1 !reply_valid)
    else $error("bad segment answered");

  a_bad_loc: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_LOC_WRITE && (loc_num == 7'h00 || loc_num > LOC_MAX))
    |-> !loc_we ##1 error_push)
    else $error("invalid location written");

  a_sync_update: assert property (@(posedge clk) disable iff (!rst_b)
    (sync_mode && setpoint_changed) ##1 (sync_mode && !setpoint_changed)[*8] |-> !sample_stb)
    else $error("sync sample too early");

  a_tran_bound: assert property (@(posedge clk) disable iff (!rst_b)
    (reply_valid && op_q == CMD_TRAN_QRY) |-> tran_index <= 3'h7)
    else $error("transient index overrun");

  // =====================================================
  // Reply lengths and settings
  // Counted from the taking edge: busy first, then one word a cycle
  a_seg_level: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_SEG_QRY && seg_ok && seg_type == SEG_LEVEL)
    |=> ##3 (reply_valid && reply_last)) else $error("level segment not three words");

  a_seg_plain: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_SEG_QRY && seg_ok && seg_type != SEG_LEVEL && !seg_angles)
    |=> ##4 (reply_valid && reply_last)) else $error("segment not four words");

  a_seg_angles: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_SEG_QRY && seg_ok && seg_angles)
    |=> ##6 (reply_valid && reply_last)) else $error("angled segment not six words");

  a_tran_full: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_TRAN_QRY && tran_count == 4'h8)
    |=> ##8 (reply_valid && reply_last)) else $error("transient reply not eight words");

  a_tran_empty: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_TRAN_QRY && tran_count == 4'h0)
    |=> !busy && !error_push) else $error("empty transient answered");

  a_rate_taken: assert property (@(posedge clk) disable iff (!rst_b)
    (rate_init_q && is_cmd && cmd_code == CMD_RATE_SET && rate_arg_ok)
    |=> sample_rate == $past(cmd_arg[6:0])) else $error("legal rate not taken");

  a_sync_taken: assert property (@(posedge clk) disable iff (!rst_b)
    (is_cmd && cmd_code == CMD_SYNC_SET) |=> sync_mode == $past(cmd_arg[0]))
    else $error("sync selection not taken");

  a_keyword_word: assert property (@(posedge clk) disable iff (!rst_b)
    (reply_valid && reply_kind == RK_KEYWORD) |-> reply_word == {15'h0, sync_mode})
    else $error("sync keyword wrong");

  a_power_up_free: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rate_init_q) |-> !sync_mode) else $error("not free running at start");

  a_power_up_rate: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rate_init_q) |-> sample_rate == ($past(meter_fast) ? RATE_100 : RATE_60))
    else $error("power-up rate wrong");
endmodule

//--- hdl/combined_measure_query_mem_pkg.sv
package combined_measure_query_mem_pkg;
  // =====================================================
  // Status byte layout
  localparam int ST_OUT_ON = 0;
  localparam int ST_LIST_RUN = 1;
  localparam int ST_ERR_PEND = 2;
  localparam int ST_REG_MODE = 3;
  localparam int ST_PROT = 4;
  localparam int ST_FAULT = 5;
  // =====================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SYNC_UPDATE_MS = 60;
  localparam int FREE_UPDATE_MS = 25;
  localparam int SYNC_UPDATE_CYC = SYNC_UPDATE_MS * (CLK_HZ / 1000);
  localparam int FREE_UPDATE_CYC = FREE_UPDATE_MS * (CLK_HZ / 1000);
  // =====================================================
  // Rates, limits, counts
  localparam logic [6:0] RATE_50 = 7'h32;
  localparam logic [6:0] RATE_60 = 7'h3c;
  localparam logic [6:0] RATE_100 = 7'h64;
  localparam logic [6:0] LOC_MIN = 7'h01;
  localparam logic [6:0] LOC_MAX = 7'h63;
  localparam int LOC_DEPTH = 100;
  localparam int TRAN_MAX = 8;
  localparam int SEG_DEPTH = 16;
  localparam int VAL_W = 16;
  localparam logic [15:0] ANGLE_360 = 16'h0168;
  // =====================================================
  // Command codes
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_COMBINED = 4'h1,
    CMD_CURR = 4'h2,
    CMD_VOLT = 4'h3,
    CMD_SYNC_SET = 4'h4,
    CMD_SYNC_QRY = 4'h5,
    CMD_RATE_SET = 4'h6,
    CMD_RATE_QRY = 4'h7,
    CMD_TRAN_QRY = 4'h8,
    CMD_SEG_QRY = 4'h9,
    CMD_LOC_WRITE = 4'ha
  } cmd_t;
  typedef enum logic [1:0] {
    REG_VOLT = 2'h0, REG_CURR = 2'h1, REG_PIN = 2'h2
  } reg_mode_t;
  typedef enum logic [1:0] {
    REF_FIXED = 2'h0, REF_EXT = 2'h1, REF_GAIN = 2'h2, REF_ADD = 2'h3
  } ref_mode_t;
  typedef enum logic [1:0] {
    PROT_DIGITAL = 2'h0, PROT_ANALOG = 2'h1, PROT_SMALLER = 2'h2
  } prot_mode_t;
  typedef enum logic [2:0] {
    SEG_SQUARE = 3'h0, SEG_RAMP_UP = 3'h1, SEG_RAMP_DN = 3'h2,
    SEG_TRIANGLE = 3'h3, SEG_SINE = 3'h4, SEG_LEVEL = 3'h5
  } seg_type_t;
  // Reply word kinds
  typedef enum logic [2:0] {
    RK_NUM = 3'h0, RK_STATUS = 3'h1, RK_KEYWORD = 3'h2, RK_INT = 3'h3, RK_SEGTYPE = 3'h4
  } reply_kind_t;
  // Field presence mask bits for a location write
  localparam int F_VSET = 0;
  localparam int F_CSET = 1;
  localparam int F_PPROT = 2;
  localparam int F_NPROT = 3;
  localparam int F_OUT = 4;
  localparam int F_REF = 5;
  localparam int F_PMODE = 6;
  localparam int F_MODE = 7;
endpackage

//--- hdl/update_timer.sv
`timescale 1ns/1ns
module update_timer
  import combined_measure_query_mem_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sync_mode,
  input wire logic setpoint_changed,
  output logic sample_stb
);
  // =====================================================
  // Measurement update pacing
  logic [31:0] cnt_q;
  logic armed_q;
  wire [31:0] limit = sync_mode ? 32'(SYNC_UPDATE_CYC - 1) : 32'(FREE_UPDATE_CYC - 1);
  wire expire = (cnt_q >= limit);
  // Sync mode only samples once after a setpoint change
  wire fire = expire && (!sync_mode || armed_q);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0;
      armed_q <= 1'b0;
      sample_stb <= 1'b0;
    end else begin
      sample_stb <= fire;
      if (setpoint_changed) begin
        cnt_q <= 32'h0;
        armed_q <= 1'b1;
      end else if (expire) begin
        cnt_q <= 32'h0;
        if (fire) armed_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end
endmodule

//--- dv/far_side_model.sv
`timescale 1ns/1ns
module far_side_model
  import combined_measure_query_mem_pkg::*;
(
  input wire logic [2:0] tran_index,
  input wire logic [15:0] seg_num,
  output logic [15:0] tran_sample,
  output logic [4:0] seg_loaded,
  output logic [2:0] seg_type,
  output logic [15:0] seg_val1,
  output logic [15:0] seg_val2,
  output logic [15:0] seg_val3,
  output logic [15:0] seg_start,
  output logic [15:0] seg_stop
);
  // =====================================================
  // Samples of the last list, distinct per slot
  assign tran_sample = 16'ha500 + {13'h0, tran_index};
  // =====================================================
  // Segments: level, sine with angles, full sine, full triangle
  assign seg_loaded = 5'h04;
  assign seg_type = (seg_num == 16'h0) ? SEG_LEVEL : (seg_num == 16'h3) ? SEG_TRIANGLE : SEG_SINE;
  assign seg_val1 = 16'h0100 + seg_num;
  assign seg_val2 = 16'h0200 + seg_num;
  assign seg_val3 = 16'h0300 + seg_num;
  assign seg_start = (seg_num == 16'h1) ? 16'h005a : 16'h0000;
  assign seg_stop = (seg_num == 16'h1) ? 16'h00b4 : ANGLE_360;
endmodule

//--- dv/measure_and_memory_cmds_test.sv
`timescale 1ns/1ns
module measure_and_memory_cmds_test;
  import combined_measure_query_mem_pkg::*;
  logic clk = 0, rst_b = 0, cmd_valid = 0, meter_fast = 1, setpoint_changed = 0, loc_out = 0;
  logic [3:0] cmd_code = 0, tran_count = 0;
  logic [15:0] cmd_arg = 0, loc_vset = 0, loc_cset = 0, loc_pprot = 0, loc_nprot = 0;
  logic [6:0] loc_num = 0, recall_loc = 0;
  logic [7:0] loc_present = 0;
  logic [1:0] loc_mode = 0, loc_ref = 0, loc_pmode = 0;
  logic [5:0] st_in = 0;
  logic [15:0] tran_sample, seg_val1, seg_val2, seg_val3, seg_start, seg_stop, reply_word;
  logic [4:0] seg_loaded;
  logic [2:0] seg_type, tran_index, reply_kind;
  logic [70:0] recall_data;
  logic reply_valid, reply_last, busy, error_push, sync_mode;
  logic [7:0] measurement_status_byte;
  logic [6:0] sample_rate;
  logic [15:0] w_q[$];
  logic [2:0] k_q[$];
  logic l_q[$];
  logic err_seen;
  int n_errors = 0, num_checks = 0, cycles = 0;

  measure_and_memory_cmds uut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg(cmd_arg), .loc_num(loc_num), .loc_present(loc_present), .loc_mode(loc_mode), .loc_vset(loc_vset),
    .loc_cset(loc_cset), .loc_pprot(loc_pprot), .loc_nprot(loc_nprot), .loc_out(loc_out), .loc_ref(loc_ref),
    .loc_pmode(loc_pmode), .meter_fast(meter_fast), .voltage_measure_query(16'h1234), .current_measure_query(16'h0567),
    .output_on(st_in[0]), .list_running(st_in[1]), .errors_queued(st_in[2]), .current_regulation(st_in[3]),
    .protect_active(st_in[4]), .fault_no_power(st_in[5]), .setpoint_changed(setpoint_changed),
    .tran_count(tran_count), .tran_sample(tran_sample), .tran_index(tran_index), .seg_loaded(seg_loaded),
    .seg_type(seg_type), .seg_val1(seg_val1), .seg_val2(seg_val2), .seg_val3(seg_val3), .seg_start(seg_start),
    .seg_stop(seg_stop), .recall_loc(recall_loc), .recall_data(recall_data), .reply_valid(reply_valid),
    .reply_kind(reply_kind), .reply_word(reply_word), .reply_last(reply_last), .busy(busy),
    .error_push(error_push), .measurement_status_byte(measurement_status_byte), .sync_mode(sync_mode),
    .sample_rate(sample_rate));
  far_side_model partner (.tran_index(tran_index), .seg_num(cmd_arg), .tran_sample(tran_sample),
    .seg_loaded(seg_loaded), .seg_type(seg_type), .seg_val1(seg_val1), .seg_val2(seg_val2),
    .seg_val3(seg_val3), .seg_start(seg_start), .seg_stop(seg_stop));

  // =====================================================
  // Clock, hang guard, verdict
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // =====================================================
  // Shared drivers and comparisons
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic fast);
    rst_b = 0;
    meter_fast = fast;
    repeat (3) @(posedge clk);
    #1 rst_b = 1;
    @(posedge clk);
    #1;
  endtask
  // Window of 12 cycles covers the longest reply of 8 words plus latency
  task automatic issue(input logic [3:0] code, input logic [15:0] arg);
    w_q = {};
    k_q = {};
    l_q = {};
    err_seen = 0;
    cmd_code = code;
    cmd_arg = arg;
    cmd_valid = 1;
    @(posedge clk);
    #1 cmd_valid = 0;
    if (error_push === 1'b1) err_seen = 1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      #1;
      if (error_push === 1'b1) err_seen = 1;
      if (reply_valid === 1'b1) begin
        w_q.push_back(reply_word);
        k_q.push_back(reply_kind);
        l_q.push_back(reply_last);
      end
    end
  endtask
  // Words below index skip carry live measurements and are not compared
  task automatic chk_reply(input string what, input int skip, input logic [15:0] ew[$], input logic [2:0] ek[$]);
    chk({what, " count"}, 64'(ew.size()), 64'(w_q.size()));
    chk({what, " error"}, 64'(0), 64'(err_seen));
    foreach (ew[i]) if (i < w_q.size()) begin
      if (i >= skip) chk({what, " word"}, 64'(ew[i]), 64'(w_q[i]));
      chk({what, " kind"}, 64'(ek[i]), 64'(k_q[i]));
      chk({what, " last"}, 64'(i == ew.size() - 1), 64'(l_q[i]));
    end
  endtask
  task automatic chk_refused(input string what);
    chk({what, " count"}, 64'(0), 64'(w_q.size()));
    chk({what, " error"}, 64'(1), 64'(err_seen));
  endtask
  // =====================================================
  // Scenarios
  task automatic t_status();
    for (int b = 0; b < 6; b++) begin
      st_in = 6'(1 << b);
      repeat (2) @(posedge clk);
      #1 chk("status byte", 64'(1 << b), 64'(measurement_status_byte));
    end
    st_in = 6'h2a;
    issue(CMD_COMBINED, 16'h0);
    chk_reply("combined", 2, '{16'h0, 16'h0, 16'h002a}, '{RK_NUM, RK_NUM, RK_STATUS});
    issue(CMD_VOLT, 16'h0);
    chk_reply("voltage", 1, '{16'h0}, '{RK_NUM});
    issue(CMD_CURR, 16'h0);
    chk_reply("current", 1, '{16'h0}, '{RK_NUM});
    st_in = 6'h0;
  endtask
  task automatic t_sync_rate();
    issue(CMD_SYNC_SET, 16'h1);
    chk("sync mode", 64'(1), 64'(sync_mode));
    setpoint_changed = 1;
    @(posedge clk);
    #1 setpoint_changed = 0;
    issue(CMD_SYNC_QRY, 16'h0);
    chk_reply("sync query", 0, '{16'h1}, '{RK_KEYWORD});
    issue(CMD_SYNC_SET, 16'h0);
    issue(CMD_SYNC_QRY, 16'h0);
    chk_reply("async query", 0, '{16'h0}, '{RK_KEYWORD});
    for (int i = 0; i < 3; i++) begin
      issue(CMD_RATE_SET, i == 0 ? 16'd50 : i == 1 ? 16'd100 : 16'd60);
      issue(CMD_RATE_QRY, 16'h0);
      chk_reply("rate query", 0, '{i == 0 ? 16'd50 : i == 1 ? 16'd100 : 16'd60}, '{RK_INT});
    end
    issue(CMD_RATE_SET, 16'd70);
    chk_refused("bad rate");
    chk("rate kept", 64'(RATE_60), 64'(sample_rate));
  endtask
  task automatic t_lists();
    tran_count = 4'h8;
    issue(CMD_TRAN_QRY, 16'h0);
    chk_reply("transient", 0, '{16'ha500, 16'ha501, 16'ha502, 16'ha503, 16'ha504, 16'ha505, 16'ha506, 16'ha507},
      '{RK_NUM, RK_NUM, RK_NUM, RK_NUM, RK_NUM, RK_NUM, RK_NUM, RK_NUM});
    tran_count = 4'h0;
    issue(CMD_TRAN_QRY, 16'h0);
    chk("empty transient", 64'(0), 64'(w_q.size() + err_seen));
    issue(CMD_SEG_QRY, 16'h0);
    chk_reply("level seg", 0, '{16'h0005, 16'h0100, 16'h0200}, '{RK_SEGTYPE, RK_NUM, RK_NUM});
    issue(CMD_SEG_QRY, 16'h1);
    chk_reply("sine seg", 0, '{16'h0004, 16'h0101, 16'h0201, 16'h0301, 16'h005a, 16'h00b4},
      '{RK_SEGTYPE, RK_NUM, RK_NUM, RK_NUM, RK_NUM, RK_NUM});
    issue(CMD_SEG_QRY, 16'h2);
    chk_reply("full sine", 0, '{16'h0004, 16'h0102, 16'h0202, 16'h0302}, '{RK_SEGTYPE, RK_NUM, RK_NUM, RK_NUM});
    issue(CMD_SEG_QRY, 16'h3);
    chk_reply("triangle", 0, '{16'h0003, 16'h0103, 16'h0203, 16'h0303}, '{RK_SEGTYPE, RK_NUM, RK_NUM, RK_NUM});
    issue(CMD_SEG_QRY, 16'h4);
    chk_refused("missing seg");
  endtask
  task automatic t_memory();
    {loc_num, loc_mode, loc_vset, loc_cset, loc_pprot, loc_nprot, loc_out} = {7'd10, REG_PIN, 16'h1111, 16'h2222,
      16'h4444, 16'h5555, 1'b1};
    {loc_ref, loc_pmode, loc_present} = {REF_ADD, PROT_SMALLER, 8'hff};
    issue(CMD_LOC_WRITE, 16'h0);
    recall_loc = 7'd10;
    repeat (2) @(posedge clk);
    #1 chk("full recall", {30'h0, 16'h2222, 16'h1111, REG_PIN}, {30'h0, recall_data[33:0]});
    chk("full recall hi", {27'h0, PROT_SMALLER, REF_ADD, 1'b1, 16'h5555, 16'h4444},
      {27'h0, recall_data[70:34]});
    chk("output untouched", 64'(0), 64'(measurement_status_byte[ST_OUT_ON]));
    {loc_mode, loc_vset, loc_present} = {REG_CURR, 16'h3333, 8'h81};
    issue(CMD_LOC_WRITE, 16'h0);
    #1 chk("partial recall", {30'h0, 16'h0000, 16'h3333, REG_CURR}, {30'h0, recall_data[33:0]});
    chk("partial recall hi", 64'(0), {27'h0, recall_data[70:34]});
    loc_num = 7'd99;
    issue(CMD_LOC_WRITE, 16'h0);
    chk("top location", 64'(0), 64'(err_seen + w_q.size()));
    for (int i = 0; i < 2; i++) begin
      loc_num = i == 0 ? 7'd0 : 7'd100;
      issue(CMD_LOC_WRITE, 16'h0);
      chk_refused("bad location");
    end
  endtask
  // =====================================================
  // Main sequence
  initial begin
    do_reset(1'b1);
    chk("fast rate", 64'(RATE_100), 64'(sample_rate));
    setpoint_changed = 1;
    do_reset(1'b0);
    setpoint_changed = 0;
    chk("slow rate", 64'(RATE_60), 64'(sample_rate));
    chk("free running", 64'(0), 64'(sync_mode));
    t_status();
    t_sync_rate();
    t_lists();
    t_memory();
    finish_test();
  end
endmodule
